// [ics_pkg.sv]
// Package with constants, register map, states and carrier types of the integrator CDS sequencer.
package ics_pkg;

    localparam int NUM_CH = 64;
    localparam int LVL_W = 16;
    localparam int CDS_W = 17;

    localparam int CLK_MHZ = 200;
    localparam int FILT_TC_NS = 1000;
    localparam int FILT_TC_CYC = (FILT_TC_NS * CLK_MHZ) / 1000;

    localparam logic [6:0] RST_OPEN_SEQ = 7'h20;
    localparam logic [6:0] RST_OPEN_SIM = 7'h08;
    localparam logic [6:0] BYPASS_END = 7'h40;
    localparam logic [6:0] FALL_CNT_MAX = 7'h7F;

    localparam logic [7:0] READ_CLKS_SEQ = 8'h82;
    localparam logic [7:0] READ_CLKS_SIM = 8'h21;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_RST_SMP = 5'h08;
    localparam logic [4:0] OFS_SIG_SMP = 5'h0C;
    localparam logic [4:0] OFS_CDS = 5'h10;
    localparam logic [4:0] OFS_CLKCNT = 5'h14;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLRVALID_BIT = 1;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [7:0] FILT_CNT_W0 = 8'h00;

    localparam int NUM_PINS = 9;

    typedef enum logic [1:0] {
        ICS_IDLE = 2'b00,
        ICS_RESET_PH = 2'b01,
        ICS_INTEG = 2'b10,
        ICS_HELD = 2'b11
    } ics_state_t;

    // Pin inputs from the scan timing controller, all asynchronous to ref_clk_i.
    typedef struct packed {
        logic scan_clk;
        logic integrator_reset_strobe;
        logic reset_sample_strobe;
        logic signal_sample_strobe;
        logic integrate_window;
        logic readout_start_pulse;
        logic charge_dump_control;
        logic integrate_direction_select;
        logic output_mode_select;
    } ics_pins_t;

    // Analog switch and filter controls driven towards the channel array.
    typedef struct packed {
        logic reset_track;
        logic reset_filter_en;
        logic reset_hold;
        logic signal_bypass;
        logic signal_filter_en;
        logic signal_hold;
        logic dump_inject;
        logic reset_level_high;
    } ics_switch_t;

endpackage

// [ics_sync_edge.sv]
// Two-flop synchroniser for one pin with rise and fall pulses taken after the second flop.
`timescale 1ns/1ps
`default_nettype none

module ics_sync_edge (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Pin and results
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic meta;
    logic stable;
    logic last;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= 1'b0;
            stable <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin_i;
            stable <= meta;
            last <= stable;
        end
    end

    assign level_o = stable;
    assign rise_o = stable & ~last;
    assign fall_o = ~stable & last;

endmodule

`default_nettype wire

// [ics_sequencer.sv]
// Integration, reset sampling and correlated double sampling sequencer with an Avalon-MM register slave.
//
// How it works
// - Reset strobe rise starts reset; reset-sample rise ends it.
// - Reset switch open after clock 32 sequential, 8 simultaneous.
// - Tracking and bypass end at clock 64 falling edge.
// - Reset sample strobe rise captures integrator reset level.
// - All channels reset to low or high reference.
// - Window fall enables signal filter, one microsecond constant.
// - Integration runs regardless of window; window only bypasses.
// - Signal strobe rise captures; output is signal minus reset.
// - Signal strobe fall ends integration; results held.
// - End-of-read low while data read runs, else high.
// - Integration and data read functions each scan.
// - Charge dump input injects compensation charge.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ics_sequencer (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Controller pins
    input wire ics_pkg::ics_pins_t pins_i,
    // Integrator level from the converter, same clock
    input wire logic [15:0] integ_level_i,
    // Channel array controls
    output logic [63:0] reset_switch_o,
    output ics_pkg::ics_switch_t switches_o,
    output logic results_valid_o,
    output logic end_of_read_o,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);

    // Synchronised pins.
    logic [ics_pkg::NUM_PINS-1:0] pin_vec;
    logic [ics_pkg::NUM_PINS-1:0] lvl;
    logic [ics_pkg::NUM_PINS-1:0] rise;
    logic [ics_pkg::NUM_PINS-1:0] fall;

    assign pin_vec = pins_i;

    genvar gi;
    generate
        for (gi = 0; gi < ics_pkg::NUM_PINS; gi++) begin : g_sync
            ics_sync_edge u_sync (
                .ref_clk_i(ref_clk_i),
                .resetn_i(resetn_i),
                .pin_i(pin_vec[gi]),
                .level_o(lvl[gi]),
                .rise_o(rise[gi]),
                .fall_o(fall[gi])
            );
        end
    endgenerate

    // Bit positions follow the packed struct, first member at the top.
    wire clk_rise = rise[8];
    wire clk_fall = fall[8];
    wire integrator_reset_strobe_rise = rise[7];
    wire rsmp_rise = rise[6];
    wire ssmp_rise = rise[5];
    wire ssmp_fall = fall[5];
    wire win_lvl = lvl[4];
    wire win_fall = fall[4];
    wire start_rise = rise[3];
    wire start_fall = fall[3];
    wire dump_lvl = lvl[2];
    wire dir_lvl = lvl[1];
    wire mode_lvl = lvl[0];

    // Control and state registers.
    ics_pkg::ics_state_t state;
    logic enable;
    logic dir_lat;
    logic mode_lat;
    logic [6:0] fall_cnt;
    logic [15:0] rst_sample;
    logic [15:0] sig_sample;
    logic [16:0] cds;
    logic valid;
    logic reading;
    logic [7:0] rd_cnt;
    logic [7:0] filt_cnt;
    logic rst_hold;
    logic sig_hold;

    wire [6:0] open_limit = mode_lat ? ics_pkg::RST_OPEN_SIM : ics_pkg::RST_OPEN_SEQ;
    wire [7:0] read_len = mode_lat ? ics_pkg::READ_CLKS_SIM : ics_pkg::READ_CLKS_SEQ;
    wire in_reset = (state == ics_pkg::ICS_RESET_PH);
    wire in_integ = (state == ics_pkg::ICS_INTEG);
    wire start_reset = integrator_reset_strobe_rise & enable;
    wire reset_switch_on = in_reset & (fall_cnt < open_limit);
    wire track_on = in_reset & (fall_cnt < ics_pkg::BYPASS_END);
    wire sig_filter_on = in_integ & ~win_lvl & ~sig_hold;
    wire filt_settled = (filt_cnt == 8'(ics_pkg::FILT_TC_CYC));
    wire [16:0] next_cds = {1'b0, integ_level_i} - {1'b0, rst_sample};

    // Bus decode.
    wire bus_req = avs_read_i | avs_write_i;
    logic bus_ack;
    wire wr_take = avs_write_i & bus_ack;
    wire sel_ctrl = (avs_address_i == ics_pkg::OFS_CTRL);
    wire clr_valid = wr_take & sel_ctrl & avs_byteenable_i[0] & avs_writedata_i[ics_pkg::CTRL_CLRVALID_BIT];
    wire set_valid = in_integ & ssmp_fall;

    // Sequencer state.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ics_pkg::ICS_IDLE;
            fall_cnt <= 7'h00;
            dir_lat <= 1'b0;
            mode_lat <= 1'b0;
            rst_hold <= 1'b0;
            sig_hold <= 1'b0;
        end else if (start_reset) begin
            state <= ics_pkg::ICS_RESET_PH;
            fall_cnt <= 7'h00;
            dir_lat <= dir_lvl;
            mode_lat <= mode_lvl;
            rst_hold <= 1'b0;
            sig_hold <= 1'b0;
        end else begin
            unique case (state)
                ics_pkg::ICS_IDLE: begin
                    state <= ics_pkg::ICS_IDLE;
                end
                ics_pkg::ICS_RESET_PH: begin
                    if (clk_fall && fall_cnt != ics_pkg::FALL_CNT_MAX) begin
                        fall_cnt <= fall_cnt + 7'h01;
                    end
                    if (rsmp_rise) begin
                        state <= ics_pkg::ICS_INTEG;
                        rst_hold <= 1'b1;
                    end
                end
                ics_pkg::ICS_INTEG: begin
                    if (ssmp_rise) begin
                        sig_hold <= 1'b1;
                    end
                    if (ssmp_fall) begin
                        state <= ics_pkg::ICS_HELD;
                    end
                end
                ics_pkg::ICS_HELD: begin
                    state <= ics_pkg::ICS_HELD;
                end
            endcase
        end
    end

    // Sample capture and difference.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sample <= 16'h0000;
            sig_sample <= 16'h0000;
            cds <= 17'h00000;
        end else begin
            if (in_reset && rsmp_rise) begin
                rst_sample <= integ_level_i;
            end
            if (in_integ && ssmp_rise && !sig_hold) begin
                sig_sample <= integ_level_i;
                cds <= next_cds;
            end
        end
    end

    // Result flag: a new result wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid <= 1'b0;
        end else if (set_valid) begin
            valid <= 1'b1;
        end else if (clr_valid || start_reset) begin
            valid <= 1'b0;
        end
    end

    // Signal filter settling time after the window falls.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            filt_cnt <= ics_pkg::FILT_CNT_W0;
        end else if (!sig_filter_on || win_fall) begin
            filt_cnt <= ics_pkg::FILT_CNT_W0;
        end else if (!filt_settled) begin
            filt_cnt <= filt_cnt + 8'h01;
        end
    end

    // Data read window, counted in scan clock rises.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reading <= 1'b0;
            rd_cnt <= 8'h00;
        end else if (start_rise) begin
            reading <= 1'b0;
            rd_cnt <= 8'h00;
        end else if (start_fall) begin
            reading <= 1'b1;
            rd_cnt <= 8'h00;
        end else if (reading && clk_rise) begin
            if (rd_cnt == read_len - 8'h01) begin
                reading <= 1'b0;
            end
            rd_cnt <= rd_cnt + 8'h01;
        end
    end

    // Outputs towards the channel array.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reset_switch_o <= '0;
            switches_o <= '0;
            end_of_read_o <= 1'b1;
        end else begin
            reset_switch_o <= {ics_pkg::NUM_CH{reset_switch_on}};
            switches_o.reset_track <= track_on;
            switches_o.reset_filter_en <= in_reset & ~track_on;
            switches_o.reset_hold <= rst_hold;
            switches_o.signal_bypass <= in_integ & win_lvl & ~sig_hold;
            switches_o.signal_filter_en <= sig_filter_on;
            switches_o.signal_hold <= sig_hold;
            switches_o.dump_inject <= dump_lvl;
            switches_o.reset_level_high <= dir_lat;
            end_of_read_o <= ~reading;
        end
    end

    assign results_valid_o = valid;

    // Avalon-MM slave: one wait cycle, read data registered in it.
    logic [31:0] rdata;
    wire [31:0] status_word = {16'h0000, 8'(rd_cnt), filt_settled, win_lvl, mode_lat, dir_lat,
                               ~reading, valid, 2'(state)};
    always_comb begin
        unique case (avs_address_i)
            ics_pkg::OFS_CTRL: rdata = {31'h00000000, enable};
            ics_pkg::OFS_STATUS: rdata = status_word;
            ics_pkg::OFS_RST_SMP: rdata = {16'h0000, rst_sample};
            ics_pkg::OFS_SIG_SMP: rdata = {16'h0000, sig_sample};
            ics_pkg::OFS_CDS: rdata = {{15{cds[16]}}, cds};
            ics_pkg::OFS_CLKCNT: rdata = {25'h0000000, fall_cnt};
            default: rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_ack <= 1'b0;
            avs_readdata_o <= 32'h00000000;
            enable <= ics_pkg::CTRL_ENABLE_RST;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
            if (avs_read_i && !bus_ack) begin
                avs_readdata_o <= rdata;
            end
            if (wr_take && sel_ctrl && avs_byteenable_i[0]) begin
                enable <= avs_writedata_i[ics_pkg::CTRL_ENABLE_BIT];
            end
        end
    end

    assign avs_waitrequest_o = bus_req & ~bus_ack;

    // Checks.
    reset_start_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        start_reset |=> state == ics_pkg::ICS_RESET_PH)
        else $error("reset strobe did not start the reset phase");

    switch_open_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (in_reset && fall_cnt >= open_limit && !start_reset) |=> !reset_switch_o[0])
        else $error("integrator reset switch still closed past its clock");

    bypass_end_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (in_reset && clk_fall && fall_cnt == 7'h3F && !rsmp_rise && !start_reset)
        |=> ##1 (!switches_o.reset_track && switches_o.reset_filter_en))
        else $error("bypass not opened at clock 64 falling edge");

    reset_capture_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (in_reset && rsmp_rise && !start_reset) |=> rst_sample == $past(integ_level_i) && in_integ)
        else $error("reset level not captured");

    ref_level_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        start_reset |=> ##1 switches_o.reset_level_high == $past(dir_lvl, 2))
        else $error("reset reference does not follow direction");

    window_filter_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (in_integ && win_fall && !sig_hold && !start_reset && !ssmp_fall) |=> switches_o.signal_filter_en)
        else $error("signal filter not enabled on window fall");

    cds_diff_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (in_integ && ssmp_rise && !sig_hold && !start_reset) |=> cds == sig_sample - {1'b0, rst_sample})
        else $error("difference does not match the two samples");

    result_held_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (in_integ && ssmp_fall && !start_reset) |=> (valid && state == ics_pkg::ICS_HELD))
        else $error("results not held after signal strobe fall");

    read_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reading |=> !end_of_read_o)
        else $error("end-of-read high during data read");

    dump_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ##1 switches_o.dump_inject == $past(dump_lvl))
        else $error("charge dump does not follow its input");

    bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");

endmodule

`default_nettype wire

// [ics_ctrl_model.sv]
// Behavioural scan timing controller that drives the strobe, clock and select pins.
`timescale 1ns/1ps
`default_nettype none

module ics_ctrl_model (
    // Clock
    input wire logic ref_clk_i,
    // Pins towards the sequencer
    output var ics_pkg::ics_pins_t pins_o
);
    initial begin
        pins_o = '0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Every change starts right after a rising edge, so the pins never move at a sampling point.
    task automatic set(input int b, input logic v);
        @(posedge ref_clk_i);
        pins_o[b] <= v;
    endtask

    // Pulses are four cycles wide, above the one-cycle minimum of the synchronisers.
    task automatic pulse(input int b);
        set(b, 1'b1);
        tick(4);
        pins_o[b] <= 1'b0;
    endtask

    // The scan clock stands low between frames and runs only while a task asks for it.
    task automatic sclk(input int n);
        repeat (n) begin
            set(8, 1'b1);
            tick(3);
            pins_o[8] <= 1'b0;
            tick(4);
        end
    endtask
endmodule

`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the integrator CDS sequencer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    ics_pkg::ics_pins_t pins;
    logic [15:0] level;
    logic [63:0] rsw;
    ics_pkg::ics_switch_t sw;
    logic valid;
    logic eor;
    logic wait_o;
    logic [4:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic [31:0] q;
    int errors = 0;
    int n_tests = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    ics_ctrl_model ctl (
        .ref_clk_i(ref_clk_i),
        .pins_o(pins)
    );

    ics_sequencer dut (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pins_i(pins),
        .integ_level_i(level),
        .reset_switch_o(rsw),
        .switches_o(sw),
        .results_valid_o(valid),
        .end_of_read_o(eor),
        .avs_address_i(addr),
        .avs_read_i(rd),
        .avs_write_i(wr),
        .avs_writedata_i(wdata),
        .avs_byteenable_i(be),
        .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_o)
    );

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Waitrequest and read data are taken as they stand just before the rising edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] e = 4'hF);
        int t;
        logic busy;
        t = 0;
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        be <= e;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge ref_clk_i);
            t++;
        end while (wait_o && t < 50);
        busy = wait_o;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (busy) chk("waitrequest", 1, 0);
    endtask

    task automatic t_reset;
        #1;
        chk("end_of_read", eor, 1);
        chk("valid", valid, 0);
        chk("switch_any", |rsw, 0);
        bus(1, ics_pkg::OFS_CTRL, 32'h00000000, 4'h0);
        bus(0, ics_pkg::OFS_CTRL, 0);
        chk("ctrl", q, 1);
        bus(1, 5'h18, 32'hFFFFFFFF);
        bus(0, 5'h18, 0);
        chk("unmapped", q, 0);
        $display("test reset done");
    endtask

    task automatic t_scan(input logic mode, input logic dir, input logic win, input logic [15:0] a,
                          input logic [15:0] b);
        int n;
        logic [16:0] d;
        n = mode ? 8 : 32;
        d = {1'b0, b} - {1'b0, a};
        ctl.set(1, dir);
        ctl.set(0, mode);
        ctl.pulse(7);
        wt(6);
        chk("switch_closed", &rsw, 1);
        chk("track", sw.reset_track, 1);
        chk("level_high", sw.reset_level_high, dir);
        ctl.sclk(n - 1);
        wt(2);
        chk("switch_held", |rsw, 1);
        ctl.sclk(1);
        wt(2);
        chk("switch_open", |rsw, 0);
        ctl.sclk(63 - n);
        wt(2);
        chk("track_held", sw.reset_track, 1);
        ctl.sclk(1);
        wt(2);
        chk("track_end", sw.reset_track, 0);
        chk("reset_filter", sw.reset_filter_en, 1);
        @(posedge ref_clk_i);
        level <= a;
        ctl.pulse(6);
        wt(2);
        chk("reset_hold", sw.reset_hold, 1);
        if (win) begin
            ctl.set(4, 1'b1);
            wt(6);
            chk("bypass", sw.signal_bypass, 1);
            ctl.set(4, 1'b0);
            wt(6);
            chk("signal_filter", sw.signal_filter_en, 1);
            bus(0, ics_pkg::OFS_STATUS, 0);
            chk("settling", q[7], 0);
            wt(ics_pkg::FILT_TC_CYC);
            bus(0, ics_pkg::OFS_STATUS, 0);
            chk("settled", q[7], 1);
        end
        @(posedge ref_clk_i);
        level <= b;
        ctl.set(5, 1'b1);
        wt(6);
        chk("signal_hold", sw.signal_hold, 1);
        chk("valid_early", valid, 0);
        ctl.set(5, 1'b0);
        wt(6);
        chk("valid_set", valid, 1);
        if (win) begin
            bus(1, ics_pkg::OFS_CTRL, 32'h00000003);
            wt(1);
            chk("valid_clear", valid, 0);
        end
        bus(0, ics_pkg::OFS_RST_SMP, 0);
        chk("reset_sample", q, {16'h0000, a});
        bus(0, ics_pkg::OFS_SIG_SMP, 0);
        chk("signal_sample", q, {16'h0000, b});
        bus(0, ics_pkg::OFS_CDS, 0);
        chk("cds", q, {{15{d[16]}}, d});
        bus(0, ics_pkg::OFS_STATUS, 0);
        chk("mode_dir", q[5:4], {mode, dir});
        $display("test scan done");
    endtask

    // A reset strobe latches the mode first, so the read length follows the chosen mode.
    task automatic t_read(input logic mode);
        int len;
        len = mode ? ics_pkg::READ_CLKS_SIM : ics_pkg::READ_CLKS_SEQ;
        ctl.set(0, mode);
        ctl.pulse(7);
        ctl.pulse(3);
        wt(6);
        chk("reading", eor, 0);
        ctl.sclk(len - 1);
        wt(2);
        chk("still_reading", eor, 0);
        ctl.sclk(1);
        wt(2);
        chk("read_done", eor, 1);
        $display("test read done");
    endtask

    task automatic t_misc;
        ctl.set(2, 1'b1);
        wt(6);
        chk("dump_on", sw.dump_inject, 1);
        ctl.set(2, 1'b0);
        wt(6);
        chk("dump_off", sw.dump_inject, 0);
        ctl.pulse(7);
        wt(6);
        chk("restart_valid", valid, 0);
        chk("restart_switch", &rsw, 1);
        ctl.sclk(8);
        wt(2);
        chk("reopen", |rsw, 0);
        bus(1, ics_pkg::OFS_CTRL, 0);
        ctl.pulse(7);
        wt(6);
        chk("disabled", |rsw, 0);
        bus(1, ics_pkg::OFS_CTRL, 1);
        ctl.pulse(7);
        wt(6);
        chk("enabled", &rsw, 1);
        $display("test misc done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        level <= 16'h0000;
        addr <= 5'h00;
        rd <= 1'b0;
        wr <= 1'b0;
        wdata <= 32'h00000000;
        be <= 4'hF;
        repeat (8) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_reset();
        t_scan(1'b0, 1'b0, 1'b1, 16'h1234, 16'h5678);
        t_scan(1'b1, 1'b1, 1'b0, 16'hC000, 16'h0100);
        t_misc();
        t_read(1'b1);
        t_read(1'b0);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        summarize();
    end
endmodule

`default_nettype wire
